// file: twc_pkg.sv
package twc_pkg;
    // own bus address, 7 bits
    localparam logic [6:0] DEV_ADDR = 7'h4c;
    // direction bit values
    localparam logic RW_READ = 1'b1;
    localparam logic RW_WRITE = 1'b0;
    // register pointer after reset
    localparam logic [7:0] PTR_RST = 8'h00;
    // system clock period
    localparam int CLK_NS = 8;
    // serial clock delay and deglitch time, rounded up to whole cycles
    localparam int DGL_NS = 120;
    localparam int DGL_CYC = (DGL_NS + CLK_NS - 1) / CLK_NS;
    localparam int DGL_W = $clog2(DGL_CYC + 1);
    // host serial clock quarter period, rounded up to whole cycles
    localparam int SCL_QTR_NS = 1250;
    localparam int SCL_QTR_CYC = (SCL_QTR_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_W = $clog2(SCL_QTR_CYC + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SCL_QTR_CYC - 1);
    // bit slot counts within a byte frame
    localparam logic [3:0] BIT_ACK = 4'h8;

    // host byte-level commands
    typedef enum logic [1:0] {
        CMD_START = 2'h0,
        CMD_WRITE = 2'h1,
        CMD_READ = 2'h2,
        CMD_STOP = 2'h3
    } twc_cmd_t;

    // device port states
    typedef enum logic [2:0] {
        DS_IDLE = 3'h0,
        DS_ADDR = 3'h1,
        DS_AACK = 3'h2,
        DS_PTR = 3'h3,
        DS_WACK = 3'h4,
        DS_WDATA = 3'h5,
        DS_RDATA = 3'h6,
        DS_RACK = 3'h7
    } twc_dst_t;

    // host engine states
    typedef enum logic [1:0] {
        HS_IDLE = 2'h0,
        HS_START = 2'h1,
        HS_BYTE = 2'h2,
        HS_STOP = 2'h3
    } twc_hst_t;
endpackage

// file: twc_if.sv
`timescale 1ns/1ns
interface twc_if;
    // host side drive
    logic scl_o;
    logic sda_h_o;
    logic sda_h_oe;
    // device side drive
    logic sda_d_o;
    logic sda_d_oe;
    // resolved lines; clock follows the host, data pulled high when nobody pulls low
    logic scl;
    logic sda;

    assign scl = scl_o;
    assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

    modport host (output scl_o, output sda_h_o, output sda_h_oe, input sda);
    modport dev (input scl, input sda, output sda_d_o, output sda_d_oe);
endinterface

// file: twc_filt.sv
`timescale 1ns/1ns
module twc_filt
    import twc_pkg::*;
#(
    parameter int N = DGL_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // synchronised line in, filtered and delayed line out
    input wire logic din,
    output logic dout_q
);
    logic [DGL_W-1:0] cnt_q;
    logic [DGL_W-1:0] cnt_d;
    logic dout_d;

    // a change is taken only after it has stood for n cycles
    always_comb begin
        cnt_d = '0;
        dout_d = dout_q;
        if (din != dout_q) begin
            if (cnt_q == DGL_W'(N - 1)) begin
                dout_d = din;
            end else begin
                cnt_d = cnt_q + DGL_W'(1);
            end
        end
    end

    // idle lines sit high
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_q <= '0;
            dout_q <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            dout_q <= dout_d;
        end
    end
endmodule

// file: twc_dev.sv
`timescale 1ns/1ns
// Notes on behaviour
// R1 - host clocks; data line open drain only
// R2 - answer only bus address 1001100
// R3 - host writes address byte 0x98
// R4 - select, write index, then transfer bytes
// R5 - idle lines both released high
// R6 - ignore everything until a start condition
// R7 - eighth bit: one read, zero write
// R8 - acknowledge after a matching address byte
// R9 - stop ends transfer, back to waiting
// R10 - repeated start begins a new address
// R11 - sender keeps data stable while clock high
// R12 - clock delayed and deglitched three crystal periods
// R13 - input bits sampled on filtered rising edge
// R14 - read output changes after filtered falling edge
// R15 - first written byte loads register pointer
// R16 - pointer increments after each written byte
// R17 - read returns pointed register, then increments
// R18 - port stays usable during standby
// R19 - msb first; receiver acknowledges ninth slot
// R20 - host nacks last read byte, then ends
module twc_dev
    import twc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // serial bus
    twc_if.dev bus,
    // register write side
    output logic [7:0] reg_waddr_q,
    output logic [7:0] reg_wdata_q,
    output logic reg_we_q,
    // register read side
    output logic [7:0] reg_raddr_q,
    output logic reg_re_q,
    input wire logic [7:0] reg_rdata
);
    // line synchronisers
    logic scl_s1_q;
    logic scl_s2_q;
    logic sda_s1_q;
    logic sda_s2_q;
    // filtered lines and their previous values
    logic scl_f;
    logic sda_f;
    logic scl_p_q;
    logic sda_p_q;
    // line events
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic load_rd;
    // port state
    twc_dst_t st_q;
    twc_dst_t st_d;
    logic [3:0] bit_q;
    logic [3:0] bit_d;
    logic [7:0] sr_q;
    logic [7:0] sr_d;
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic rw_q;
    logic rw_d;
    logic oe_q;
    logic oe_d;
    logic sda_o_q;
    logic [7:0] waddr_d;
    logic [7:0] wdata_d;
    logic we_d;
    logic [7:0] ptr_d;
    logic re_d;

    // two flops on each pin before any logic looks at it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
        end else begin
            scl_s1_q <= bus.scl;
            scl_s2_q <= scl_s1_q;
            sda_s1_q <= bus.sda;
            sda_s2_q <= sda_s1_q;
        end
    end

    // clock filter; data gets the same delay so start and stop stay aligned
    twc_filt #(.N(DGL_CYC)) u_scl_filt ( // [R12]
        .clock(clock),
        .rst_n(rst_n),
        .din(scl_s2_q),
        .dout_q(scl_f)
    );

    twc_filt #(.N(DGL_CYC)) u_sda_filt (
        .clock(clock),
        .rst_n(rst_n),
        .din(sda_s2_q),
        .dout_q(sda_f)
    );

    // remember filtered lines for edge finding
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
        end
    end

    // edges and bus conditions, watched in every state
    assign scl_rise = scl_f & ~scl_p_q;
    assign scl_fall = ~scl_f & scl_p_q;
    assign start_ev = scl_f & scl_p_q & sda_p_q & ~sda_f; // [R6]
    assign stop_ev = scl_f & scl_p_q & ~sda_p_q & sda_f; // [R9]
    // read a register after the address ack, or after the host acks a byte
    assign load_rd = (st_q == DS_AACK && rw_q == RW_READ) ||
                     (st_q == DS_RACK && !sr_q[0]); // [R20]

    // next state of the port
    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        sr_d = sr_q;
        tx_d = tx_q;
        rw_d = rw_q;
        oe_d = oe_q;
        waddr_d = reg_waddr_q;
        wdata_d = reg_wdata_q;
        we_d = 1'b0;
        ptr_d = reg_raddr_q;
        re_d = 1'b0;
        if (start_ev) begin
            // a repeated start keeps the old direction until a matching address
            st_d = DS_ADDR; // [R10]
            bit_d = 4'h0;
            oe_d = 1'b0;
        end else if (stop_ev) begin
            st_d = DS_IDLE; // [R9]
            oe_d = 1'b0; // [R5]
        end else begin
            unique case (st_q)
                DS_IDLE: begin
                    oe_d = 1'b0; // [R6]
                end
                DS_ADDR, DS_PTR, DS_WDATA: begin
                    if (scl_rise) begin
                        sr_d = {sr_q[6:0], sda_f}; // [R13] [R19]
                        bit_d = bit_q + 4'h1;
                    end else if (scl_fall && bit_q == BIT_ACK) begin
                        bit_d = 4'h0;
                        if (st_q == DS_ADDR) begin
                            if (sr_q[7:1] == DEV_ADDR) begin // [R2]
                                oe_d = 1'b1; // [R8]
                                rw_d = sr_q[0]; // [R7]
                                st_d = DS_AACK;
                            end else begin
                                st_d = DS_IDLE;
                            end
                        end else if (st_q == DS_PTR) begin
                            ptr_d = sr_q; // [R15]
                            oe_d = 1'b1; // [R19]
                            st_d = DS_WACK;
                        end else begin
                            waddr_d = reg_raddr_q;
                            wdata_d = sr_q;
                            we_d = 1'b1;
                            ptr_d = reg_raddr_q + 8'h01; // [R16]
                            oe_d = 1'b1; // [R19]
                            st_d = DS_WACK;
                        end
                    end
                end
                DS_AACK, DS_RACK: begin
                    if (scl_rise && st_q == DS_RACK) begin
                        sr_d = {sr_q[6:0], sda_f};
                    end else if (scl_fall) begin
                        bit_d = 4'h0;
                        if (load_rd) begin
                            tx_d = reg_rdata; // [R17]
                            ptr_d = reg_raddr_q + 8'h01; // [R17]
                            re_d = 1'b1;
                            oe_d = ~reg_rdata[7]; // [R14] [R1]
                            st_d = DS_RDATA;
                        end else if (st_q == DS_AACK) begin
                            oe_d = 1'b0;
                            st_d = DS_PTR; // [R4]
                        end else begin
                            oe_d = 1'b0;
                            st_d = DS_IDLE;
                        end
                    end
                end
                DS_WACK: begin
                    if (scl_fall) begin
                        oe_d = 1'b0;
                        st_d = DS_WDATA;
                    end
                end
                DS_RDATA: begin
                    if (scl_rise) begin
                        bit_d = bit_q + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_q == BIT_ACK) begin
                            oe_d = 1'b0; // release for the host ack
                            st_d = DS_RACK;
                        end else begin
                            tx_d = {tx_q[6:0], 1'b0};
                            oe_d = ~tx_q[6]; // [R14]
                        end
                    end
                end
            endcase
        end
    end

    // port registers; no standby gating, the port always runs
    always_ff @(posedge clock) begin // [R18]
        if (!rst_n) begin
            st_q <= DS_IDLE;
            bit_q <= 4'h0;
            sr_q <= 8'h00;
            tx_q <= 8'h00;
            rw_q <= RW_WRITE;
            oe_q <= 1'b0;
            sda_o_q <= 1'b0;
            reg_waddr_q <= PTR_RST;
            reg_wdata_q <= 8'h00;
            reg_we_q <= 1'b0;
            reg_raddr_q <= PTR_RST;
            reg_re_q <= 1'b0;
        end else begin
            st_q <= st_d;
            bit_q <= bit_d;
            sr_q <= sr_d;
            tx_q <= tx_d;
            rw_q <= rw_d;
            oe_q <= oe_d;
            sda_o_q <= 1'b0;
            reg_waddr_q <= waddr_d;
            reg_wdata_q <= wdata_d;
            reg_we_q <= we_d;
            reg_raddr_q <= ptr_d;
            reg_re_q <= re_d;
        end
    end

    // data line only ever pulled low
    assign bus.sda_d_o = sda_o_q; // [R1]
    assign bus.sda_d_oe = oe_q;
endmodule

// file: twc_host.sv
`timescale 1ns/1ns
module twc_host
    import twc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // serial bus
    twc_if.host bus,
    // byte command request
    input wire logic cmd_valid,
    input wire twc_cmd_t cmd,
    input wire logic [7:0] cmd_wdata,
    input wire logic cmd_last,
    output logic cmd_ready_q,
    // command answer
    output logic done_q,
    output logic [7:0] rdata_q,
    output logic nack_q
);
    logic sda_s1_q;
    logic sda_s2_q;
    twc_hst_t st_q;
    twc_hst_t st_d;
    logic [TICK_W-1:0] tick_q;
    logic [TICK_W-1:0] tick_d;
    logic [1:0] qtr_q;
    logic [1:0] qtr_d;
    logic [3:0] bit_q;
    logic [3:0] bit_d;
    logic [7:0] sh_q;
    logic [7:0] sh_d;
    logic rd_q;
    logic rd_d;
    logic last_q;
    logic last_d;
    logic scl_q;
    logic scl_d;
    logic oe_q;
    logic oe_d;
    logic sda_o_q;
    logic ready_d;
    logic done_d;
    logic [7:0] rdata_d;
    logic nack_d;

    // data line synchroniser
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
        end else begin
            sda_s1_q <= bus.sda;
            sda_s2_q <= sda_s1_q;
        end
    end

    // each step has four quarters: data, clock high, sample, clock low
    always_comb begin
        st_d = st_q;
        tick_d = tick_q;
        qtr_d = qtr_q;
        bit_d = bit_q;
        sh_d = sh_q;
        rd_d = rd_q;
        last_d = last_q;
        scl_d = scl_q;
        oe_d = oe_q;
        done_d = 1'b0;
        rdata_d = rdata_q;
        nack_d = nack_q;
        if (st_q == HS_IDLE) begin
            if (cmd_valid && cmd_ready_q) begin
                tick_d = '0;
                qtr_d = 2'h0;
                bit_d = 4'h0;
                sh_d = cmd_wdata;
                rd_d = (cmd == CMD_READ);
                last_d = cmd_last;
                unique case (cmd)
                    CMD_START: st_d = HS_START;
                    CMD_WRITE, CMD_READ: st_d = HS_BYTE;
                    CMD_STOP: st_d = HS_STOP;
                endcase
            end
        end else begin
            tick_d = tick_q + TICK_W'(1);
            if (tick_q == TICK_LAST) begin
                tick_d = '0;
                qtr_d = qtr_q + 2'h1;
                unique case (qtr_q)
                    2'h0: begin
                        if (st_q == HS_START) begin
                            oe_d = 1'b0;
                        end else if (st_q == HS_STOP) begin
                            oe_d = 1'b1;
                        end else if (bit_q != BIT_ACK) begin
                            oe_d = ~rd_q & ~sh_q[7]; // [R19] [R11]
                        end else begin
                            oe_d = rd_q & ~last_q; // [R20]
                        end
                    end
                    2'h1: scl_d = 1'b1; // [R1]
                    2'h2: begin
                        if (st_q == HS_START) begin
                            oe_d = 1'b1; // [R10]
                        end else if (st_q == HS_STOP) begin
                            oe_d = 1'b0; // [R9] [R5]
                        end else if (bit_q != BIT_ACK) begin
                            sh_d = {sh_q[6:0], sda_s2_q};
                        end else begin
                            nack_d = sda_s2_q; // [R19]
                        end
                    end
                    2'h3: begin
                        if (st_q == HS_BYTE && bit_q != BIT_ACK) begin
                            scl_d = 1'b0;
                            bit_d = bit_q + 4'h1;
                        end else begin
                            scl_d = (st_q == HS_STOP);
                            rdata_d = sh_q;
                            done_d = 1'b1;
                            st_d = HS_IDLE;
                        end
                    end
                endcase
            end
        end
        ready_d = (st_d == HS_IDLE);
    end

    // host registers; bus idles released and high
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_q <= HS_IDLE;
            tick_q <= '0;
            qtr_q <= 2'h0;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            rd_q <= 1'b0;
            last_q <= 1'b0;
            scl_q <= 1'b1;
            oe_q <= 1'b0;
            sda_o_q <= 1'b0;
            cmd_ready_q <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= 8'h00;
            nack_q <= 1'b0;
        end else begin
            st_q <= st_d;
            tick_q <= tick_d;
            qtr_q <= qtr_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            rd_q <= rd_d;
            last_q <= last_d;
            scl_q <= scl_d;
            oe_q <= oe_d;
            sda_o_q <= 1'b0;
            cmd_ready_q <= ready_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
            nack_q <= nack_d;
        end
    end

    assign bus.scl_o = scl_q;
    assign bus.sda_h_o = sda_o_q;
    assign bus.sda_h_oe = oe_q;
endmodule

// file: twc_chk.sv
`timescale 1ns/1ns
module twc_chk
    import twc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // bus signals of both ends
    input wire logic scl_o,
    input wire logic sda_h_o,
    input wire logic sda_h_oe,
    input wire logic sda_d_o,
    input wire logic sda_d_oe,
    input wire logic scl,
    input wire logic sda
);
    logic scl_q, sda_q, quiet_q, quiet_d, start_w, stop_w;
    logic [3:0] fall_q, fall_d;
    logic [7:0] sh_q, sh_d;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // raw line conditions, clock falls since start, address bits shifted in
    always_comb begin
        start_w = scl && scl_q && sda_q && !sda;
        stop_w = scl && scl_q && !sda_q && sda;
        fall_d = fall_q;
        sh_d = sh_q;
        quiet_d = quiet_q;
        if (scl_q && !scl && fall_q != 4'hf) begin
            fall_d = fall_q + 4'h1;
        end
        if (!scl_q && scl && fall_q != 4'h0 && fall_q < 4'h9) begin
            sh_d = {sh_q[6:0], sda};
        end
        if (stop_w) begin
            quiet_d = 1'b1;
        end
        if (start_w) begin
            fall_d = 4'h0;
            quiet_d = 1'b0;
        end
    end

    // helper registers; bus counts as idle out of reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            quiet_q <= 1'b1;
            fall_q <= 4'hf;
            sh_q <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            quiet_q <= quiet_d;
            fall_q <= fall_d;
            sh_q <= sh_d;
        end
    end

    chk_open_drain: assert property (sda_d_o == 1'b0 && sda_h_o == 1'b0)
        else $error("data line driven high");
    chk_quiet_idle: assert property (quiet_q |-> !sda_d_oe)
        else $error("device drives outside a frame");
    chk_ack_slot: assert property ($rose(sda_d_oe) && fall_q <= 4'h9 |-> fall_q == 4'h9)
        else $error("address acknowledge in wrong slot");
    chk_own_addr: assert property ($rose(sda_d_oe) && fall_q == 4'h9 |-> sh_q[7:1] == DEV_ADDR)
        else $error("acknowledge for a foreign address");
    chk_change_low: assert property ($changed(sda_d_oe) |-> !scl)
        else $error("device data changed while clock high");
    chk_filter_delay: assert property ($changed(sda_d_oe) |-> !$past(scl, 12))
        else $error("device output not delayed by the filter");
    chk_ack_stands: assert property ($rose(sda_d_oe) |=> sda_d_oe [*8])
        else $error("device pull too short");
    chk_stop_idle: assert property (stop_w |=> (scl_o && !sda_h_oe && !sda_d_oe) [*8])
        else $error("lines not released after stop");

    // main scenarios
    cov_start: cover property (start_w);
    cov_stop: cover property (stop_w);
    cov_addr_ack: cover property ($rose(sda_d_oe) && fall_q == 4'h9);
    cov_read_drive: cover property ($rose(sda_d_oe) && fall_q > 4'h9);
endmodule

// file: two_wire_config_slave_tb.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
    $display("BAD t=%0t got %h exp %h", $time, got, exp); end end
module two_wire_config_slave_tb
    import twc_pkg::*;
();
    logic clock = 1'b0;
    logic rst_n, cmd_valid, cmd_last, reg_we_q, reg_re_q, cmd_ready_q, done_q, nack_q;
    twc_cmd_t cmd;
    logic [7:0] cmd_wdata, reg_waddr_q, reg_wdata_q, reg_raddr_q, reg_rdata, rdata_q;
    logic [7:0] w_addr, w_data;
    logic [7:0] mem [0:255];
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    int we_cnt = 0;
    int re_cnt = 0;

    twc_if bus_if();
    twc_host u_twc_host(.clock(clock), .rst_n(rst_n), .bus(bus_if), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_wdata(cmd_wdata), .cmd_last(cmd_last), .cmd_ready_q(cmd_ready_q),
        .done_q(done_q), .rdata_q(rdata_q), .nack_q(nack_q));
    twc_dev u_twc_dev(.clock(clock), .rst_n(rst_n), .bus(bus_if), .reg_waddr_q(reg_waddr_q),
        .reg_wdata_q(reg_wdata_q), .reg_we_q(reg_we_q), .reg_raddr_q(reg_raddr_q),
        .reg_re_q(reg_re_q), .reg_rdata(reg_rdata));
    twc_chk u_twc_chk(.clock(clock), .rst_n(rst_n), .scl_o(bus_if.scl_o),
        .sda_h_o(bus_if.sda_h_o), .sda_h_oe(bus_if.sda_h_oe), .sda_d_o(bus_if.sda_d_o),
        .sda_d_oe(bus_if.sda_d_oe), .scl(bus_if.scl), .sda(bus_if.sda));

    // 125 MHz clock
    initial begin
        forever #4 clock = ~clock;
    end

    // register file beside the device, read combinationally at the pointer
    assign reg_rdata = mem[reg_raddr_q];
    // an unknown strobe out of reset counts as a pulse, so it cannot hide
    always @(posedge clock) begin
        if (rst_n === 1'b1 && reg_we_q !== 1'b0) begin
            mem[reg_waddr_q] <= reg_wdata_q;
            w_addr <= reg_waddr_q;
            w_data <= reg_wdata_q;
            we_cnt <= we_cnt + 1;
        end
        if (rst_n === 1'b1 && reg_re_q !== 1'b0) begin
            re_cnt <= re_cnt + 1;
        end
    end

    // hang guard, about a quarter above the expected run length
    always @(posedge clock) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            $display("BAD t=%0t timeout", $time);
            summarize();
        end
    end

    task summarize;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one host command: present when ready, then wait for its done pulse
    task automatic run(input twc_cmd_t c, input logic [7:0] d, input logic l);
        while (cmd_ready_q !== 1'b1) @(negedge clock);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd <= c;
        cmd_wdata <= d;
        cmd_last <= l;
        @(posedge clock);
        cmd_valid <= 1'b0;
        do @(negedge clock); while (done_q !== 1'b1);
    endtask

    // a byte clocked with no start before it must be ignored
    task t_no_start;
        run(CMD_WRITE, 8'h98, 1'b0);
        `CHK(nack_q, 1'b1)
        `CHK(reg_raddr_q, PTR_RST)
        $display("test no_start done");
    endtask

    // neighbouring address 1001101 gets no acknowledge
    task t_foreign;
        run(CMD_START, 8'h00, 1'b0);
        run(CMD_WRITE, 8'h9a, 1'b0);
        `CHK(nack_q, 1'b1)
        `CHK(we_cnt, 0)
        $display("test foreign done");
    endtask

    // repeated start, index at the top of the range, one data byte wraps the pointer
    task t_write;
        run(CMD_START, 8'h00, 1'b0);
        run(CMD_WRITE, 8'h98, 1'b0);
        `CHK(nack_q, 1'b0)
        run(CMD_WRITE, 8'hff, 1'b0);
        `CHK(nack_q, 1'b0)
        `CHK(reg_raddr_q, 8'hff)
        `CHK(we_cnt, 0)
        run(CMD_WRITE, 8'h3c, 1'b0);
        `CHK(nack_q, 1'b0)
        `CHK(we_cnt, 1)
        `CHK(w_addr, 8'hff)
        `CHK(w_data, 8'h3c)
        `CHK(reg_raddr_q, 8'h00)
        $display("test write done");
    endtask

    // turn round to read with a repeated start; first byte acknowledged, last not, then stop
    task t_read;
        run(CMD_START, 8'h00, 1'b0);
        run(CMD_WRITE, {DEV_ADDR, RW_READ}, 1'b0);
        `CHK(nack_q, 1'b0)
        run(CMD_READ, 8'h00, 1'b0);
        `CHK(rdata_q, 8'h5a)
        `CHK(re_cnt, 1)
        `CHK(reg_raddr_q, 8'h01)
        `CHK(nack_q, 1'b0)
        run(CMD_READ, 8'h00, 1'b1);
        `CHK(rdata_q, 8'h5b)
        `CHK(re_cnt, 2)
        `CHK(reg_raddr_q, 8'h02)
        `CHK(nack_q, 1'b1)
        run(CMD_STOP, 8'h00, 1'b0);
        `CHK(bus_if.scl, 1'b1)
        `CHK(bus_if.sda, 1'b1)
        $display("test read done");
    endtask

    // main sequence
    initial begin
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd = CMD_START;
        cmd_wdata = 8'h00;
        cmd_last = 1'b0;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        t_no_start();
        t_foreign();
        t_write();
        t_read();
        summarize();
    end
endmodule
